//--- design/fpla_pkg.sv
// shared constants, types and register map of the logical alu datapath
package fpla_pkg;

	// bus geometry
	localparam int ADDR_W = 8;
	localparam logic [2:0] SIZE_WORD = 3'h2;

	// register byte offsets
	localparam logic [ADDR_W-1:0] OFF_INSTR = 8'h00;
	localparam logic [ADDR_W-1:0] OFF_REG_IDX = 8'h04;
	localparam logic [ADDR_W-1:0] OFF_REG_DATA = 8'h08;
	localparam logic [ADDR_W-1:0] OFF_COND = 8'h0c;
	localparam logic [ADDR_W-1:0] OFF_XER = 8'h10;
	localparam logic [ADDR_W-1:0] OFF_INT_STAT = 8'h14;
	localparam logic [ADDR_W-1:0] OFF_INT_MASK = 8'h18;

	// opcode values
	localparam logic [5:0] PRIM_FIXED = 6'h1f;
	localparam logic [9:0] XO_NOR = 10'h07c;
	localparam logic [9:0] XO_OR = 10'h1bc;
	localparam logic [9:0] XO_ORC = 10'h19c;
	localparam logic [8:0] XO_NEG = 9'h068;
	localparam int NEG_OE_BIT = 9;
	localparam logic [31:0] MOST_NEG = 32'h8000_0000;

	// interrupt status bit positions
	localparam int INT_DONE = 0;
	localparam int INT_OVF = 1;
	localparam int INT_ILL = 2;
	localparam int INT_W = 3;

	// values after reset
	localparam logic [31:0] INSTR_RST = 32'h0000_0000;
	localparam logic [4:0] REG_IDX_RST = 5'h00;
	localparam logic [INT_W-1:0] INT_MASK_RST = 3'h0;

	// instruction word, most significant field first
	typedef struct packed {
		logic [5:0] prim;
		logic [4:0] first;
		logic [4:0] target;
		logic [4:0] second;
		logic [9:0] xo;
		logic rec;
	} fpla_instr_t;

	// condition field 0
	typedef struct packed {
		logic less_than_zero_flag;
		logic greater_than_zero_flag;
		logic equal_zero_flag;
		logic so;
	} fpla_cr_t;

	// fixed-point exception register subset
	typedef struct packed {
		logic so;
		logic overflow_flag;
		logic carry_flag;
	} fpla_xer_t;

	localparam fpla_cr_t CR_RST = 4'h0;
	localparam fpla_xer_t XER_RST = 3'h0;

	typedef enum logic [4:0] {
		ST_IDLE = 5'b00001,
		ST_RDA = 5'b00010,
		ST_RDB = 5'b00100,
		ST_EXEC = 5'b01000,
		ST_DONE = 5'b10000
	} fpla_state_t;

endpackage : fpla_pkg

//--- design/fpla_regfile.sv
// general register file, one registered read port and one write port
`timescale 1ns/10ps
`default_nettype none

module fpla_regfile #(
	parameter int WIDTH = 32,
	parameter int DEPTH = 32
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// read port
	input wire logic [$clog2(DEPTH)-1:0] raddr,
	output logic [WIDTH-1:0] rdata,
	// write port
	input wire logic we,
	input wire logic [$clog2(DEPTH)-1:0] waddr,
	input wire logic [WIDTH-1:0] wdata
);

	if (DEPTH < 2 || WIDTH < 1) begin : g_chk
		$error("fpla_regfile: unsupported geometry");
	end

	logic [WIDTH-1:0] mem [DEPTH];
	logic [WIDTH-1:0] rdata_q;
	wire logic collide = we && (waddr == raddr);

	// contents are not reset, software loads them
	always_ff @(posedge clk) begin
		if (we) begin
			mem[waddr] <= wdata;
		end
	end

	// write-first so a read in the write cycle sees new data
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rdata_q <= '0;
		end else begin
			rdata_q <= collide ? wdata : mem[raddr];
		end
	end

	assign rdata = rdata_q;

endmodule : fpla_regfile

`default_nettype wire

//--- design/fpla_core.sv
// logical alu datapath with negate tail, behind an ahb-lite slave
// Behaviour
// - nor: opcode 31, xo 124, target gets inverse of first or second
// - or: opcode 31, xo 444, target gets first or second
// - or-with-complement: opcode 31, xo 412, first or inverted second
// - first source bits 6-10, target 11-15, second 16-20, record bit 31
// - record set updates sign, zero and so flags of field 0; else unchanged
// - logical operations never change the exception register
// - logical operations act per bit, no carries between positions
// - negate treats words as 32-bit two's complement signed values
// - negate with overflow enable updates so and overflow flag
// - record negate sets field 0 from signed compare with zero, plus so
// - negate is inverse plus one; most negative stays, flags overflow
// - negate: xo 104 in bits 22-30, enable bit 21; carry untouched
//
// Register access over AHB-Lite and the register addresses were decided locally.
`timescale 1ns/10ps
`default_nettype none

module fpla_core
	import fpla_pkg::*;
#(
	parameter int DATA_W = 32,
	parameter int REGS = 32
) (
	// clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// ahb-lite slave
	input wire logic hsel,
	input wire logic [ADDR_W-1:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	// interrupt
	output logic irq
);

	// index fields are five bits wide and words 32 bits
	if (DATA_W != 32 || REGS != 32) begin : g_chk
		$error("fpla_core: only 32 registers of 32 bits are supported");
	end

	// bus data phase tracking
	logic dp_valid_q;
	logic dp_write_q;
	logic [ADDR_W-1:0] dp_addr_q;

	// architectural and control state
	fpla_state_t state_q;
	fpla_state_t state_d;
	fpla_instr_t ir_q;
	logic [DATA_W-1:0] a_q;
	logic [4:0] reg_idx_q;
	fpla_cr_t cr_q;
	fpla_xer_t xer_q;
	logic [INT_W-1:0] int_stat_q;
	logic [INT_W-1:0] int_stat_d;
	logic [INT_W-1:0] int_mask_q;

	// register file ports
	logic [4:0] rf_raddr;
	logic [DATA_W-1:0] rf_rdata;
	logic rf_we;
	logic [4:0] rf_waddr;
	logic [DATA_W-1:0] rf_wdata;

	// address phase: only whole-word transfers are honoured
	wire logic ap_take = hsel && htrans[1] && hready;
	wire logic ap_word = hsize == SIZE_WORD;

	// data phase decode
	wire logic dp_wr = dp_valid_q && dp_write_q;
	wire logic dp_rd = dp_valid_q && !dp_write_q;
	wire logic wr_instr = dp_wr && (dp_addr_q == OFF_INSTR);
	wire logic wr_idx = dp_wr && (dp_addr_q == OFF_REG_IDX);
	wire logic wr_reg = dp_wr && (dp_addr_q == OFF_REG_DATA);
	wire logic wr_xer = dp_wr && (dp_addr_q == OFF_XER);
	wire logic wr_mask = dp_wr && (dp_addr_q == OFF_INT_MASK);
	wire logic rd_stat = dp_rd && (dp_addr_q == OFF_INT_STAT);
	wire logic start = wr_instr && (state_q == ST_IDLE);

	// instruction decode
	// negate keeps its enable bit just above the nine-bit code
	wire logic is_fixed = ir_q.prim == PRIM_FIXED;
	wire logic is_nor = is_fixed && (ir_q.xo == XO_NOR);
	wire logic is_or = is_fixed && (ir_q.xo == XO_OR);
	wire logic is_orc = is_fixed && (ir_q.xo == XO_ORC);
	wire logic is_neg = is_fixed && (ir_q.xo[8:0] == XO_NEG);
	wire logic is_log = is_nor || is_or || is_orc;
	wire logic legal = is_log || is_neg;
	wire logic oe = is_neg && ir_q.xo[NEG_OE_BIT];
	wire logic exec = state_q == ST_EXEC;
	wire logic exec_ok = exec && legal;

	// operands: a_q is first source (or negate source), b arrives now
	wire logic [DATA_W-1:0] b_op = rf_rdata;

	// pure bitwise forms, no carry chain between positions
	wire logic [DATA_W-1:0] res_nor = ~(a_q | b_op);
	wire logic [DATA_W-1:0] res_or = a_q | b_op;
	wire logic [DATA_W-1:0] res_orc = a_q | ~b_op;
	// most negative wraps back to itself through the add
	wire logic [DATA_W-1:0] res_neg = DATA_W'(~a_q + 1'b1);
	wire logic neg_ovf = is_neg && (a_q == MOST_NEG);

	wire logic [DATA_W-1:0] result = is_neg ? res_neg :
		is_nor ? res_nor :
		is_orc ? res_orc :
		res_or;

	// exception register after this instruction
	fpla_xer_t xer_new;
	assign xer_new.so = xer_q.so | (oe && neg_ovf);
	// enable off: both flags keep their old value
	assign xer_new.overflow_flag = oe ? neg_ovf :
		xer_q.overflow_flag;
	// carry is never touched by these instructions
	assign xer_new.carry_flag = xer_q.carry_flag;

	// condition field from the signed result
	fpla_cr_t cr_new;
	assign cr_new.less_than_zero_flag =
		$signed(result) < 0;
	assign cr_new.greater_than_zero_flag =
		$signed(result) > 0;
	assign cr_new.equal_zero_flag = result == '0;
	// so taken after this instruction's own exception update
	assign cr_new.so = xer_new.so;

	// logical forms keep the exception register as it was
	wire logic xer_upd = exec_ok && oe;
	wire logic cr_upd = exec_ok && ir_q.rec;

	// events for the interrupt status
	// done fires for illegal words too, so software always sees an end
	logic [INT_W-1:0] events;
	assign events[INT_DONE] = exec;
	assign events[INT_OVF] = exec_ok && oe && neg_ovf;
	assign events[INT_ILL] = exec && !legal;

	// register file steering
	// an index write steers the read port at once, so a data read
	// straight after it already sees the newly chosen register
	wire logic [4:0] idle_raddr = wr_idx ? hwdata[4:0] : reg_idx_q;
	// first field is the source for logical forms, target for negate
	wire logic [4:0] src_a = is_neg ? ir_q.target : ir_q.first;
	wire logic [4:0] dst = is_neg ? ir_q.first : ir_q.target;

	assign rf_raddr = (state_q == ST_RDA) ? src_a :
		(state_q == ST_RDB) ? ir_q.second :
		idle_raddr;
	assign rf_we = exec_ok || wr_reg;
	assign rf_waddr = exec ? dst : reg_idx_q;
	assign rf_wdata = exec ? result : hwdata;

	fpla_regfile #(
		.WIDTH(DATA_W),
		.DEPTH(REGS)
	) u_regs (
		.clk(hclk),
		.rst_n(hresetn),
		.raddr(rf_raddr),
		.rdata(rf_rdata),
		.we(rf_we),
		.waddr(rf_waddr),
		.wdata(rf_wdata)
	);

	// sequencer: one instruction at a time, no overlap
	// four stalled cycles: decode, first fetch, second fetch, execute
	// illegal words walk the same path, so the bus timing is fixed
	always_comb begin
		state_d = state_q;
		case (state_q)
			ST_IDLE: begin
				if (start) begin
					state_d = ST_RDA;
				end
			end
			ST_RDA: begin
				state_d = ST_RDB;
			end
			ST_RDB: begin
				state_d = ST_EXEC;
			end
			ST_EXEC: begin
				state_d = ST_DONE;
			end
			ST_DONE: begin
				state_d = ST_IDLE;
			end
			default: begin
				state_d = ST_IDLE;
			end
		endcase
	end

	// sticky status: a new event beats the read that clears it
	assign int_stat_d = (rd_stat ? '0 : int_stat_q) | events;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state_q <= ST_IDLE;
		end else begin
			state_q <= state_d;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			dp_valid_q <= 1'b0;
			dp_write_q <= 1'b0;
			dp_addr_q <= '0;
		end else if (hready) begin
			dp_valid_q <= ap_take && ap_word;
			dp_write_q <= hwrite;
			dp_addr_q <= haddr;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ir_q <= INSTR_RST;
		end else if (start) begin
			ir_q <= hwdata;
		end
	end

	// first operand captured as it leaves the register file
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			a_q <= '0;
		end else if (state_q == ST_RDB) begin
			a_q <= rf_rdata;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			reg_idx_q <= REG_IDX_RST;
		end else if (wr_idx) begin
			reg_idx_q <= hwdata[4:0];
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cr_q <= CR_RST;
		end else if (cr_upd) begin
			cr_q <= cr_new;
		end
	end

	// software and execution never write in the same cycle
	// the stalled bus cannot carry a write while an instruction runs
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			xer_q <= XER_RST;
		end else if (xer_upd) begin
			xer_q <= xer_new;
		end else if (wr_xer) begin
			xer_q <= hwdata[2:0];
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			int_stat_q <= '0;
			int_mask_q <= INT_MASK_RST;
		end else begin
			int_stat_q <= int_stat_d;
			if (wr_mask) begin
				int_mask_q <= hwdata[INT_W-1:0];
			end
		end
	end

	// read data mux, unmapped offsets read zero
	// field 0 and the exception flags pack into the low bits
	wire logic [31:0] rd_mux =
		(dp_addr_q == OFF_INSTR) ? ir_q :
		(dp_addr_q == OFF_REG_IDX) ? {27'h0, reg_idx_q} :
		(dp_addr_q == OFF_REG_DATA) ? rf_rdata :
		(dp_addr_q == OFF_COND) ? {28'h0, cr_q} :
		(dp_addr_q == OFF_XER) ? {29'h0, xer_q} :
		(dp_addr_q == OFF_INT_STAT) ? {29'h0, int_stat_q} :
		(dp_addr_q == OFF_INT_MASK) ? {29'h0, int_mask_q} :
		32'h0;

	// an instruction write holds its data phase until it retires
	// reads and other writes answer without a wait state
	assign hreadyout = !wr_instr || (state_q == ST_DONE);
	assign hresp = 1'b0;
	assign hrdata = dp_rd ? rd_mux : 32'h0;
	assign irq = |(int_stat_q & int_mask_q);

endmodule : fpla_core

`default_nettype wire

//--- testbench/fpla_asserts.sv
// bus-side checks of the logical alu datapath
`timescale 1ns/10ps
`default_nettype none
module fpla_asserts
	import fpla_pkg::*;
(
	// clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// bus
	input wire logic hsel,
	input wire logic [ADDR_W-1:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	input wire logic hreadyout,
	input wire logic hresp,
	input wire logic [31:0] hrdata,
	input wire logic irq
);
	logic rp_q;
	logic [ADDR_W-1:0] pa_q;
	wire logic tk = hsel && htrans[1] && hready && hsize == SIZE_WORD;
	wire logic ins = tk && hwrite && haddr == OFF_INSTR;
	// read data phase tracker, frozen while the bus stalls
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rp_q <= 1'b0;
			pa_q <= '0;
		end else if (hready) begin
			rp_q <= tk && !hwrite;
			pa_q <= haddr;
		end
	end
	default clocking @(posedge hclk);
	endclocking
	default disable iff (!hresetn);
	a_exec_stall: assert property (
		ins |=> !hreadyout [*4] ##1 hreadyout) else $error("stall");
	a_stall_cause: assert property (
		$fell(hreadyout) |-> $past(ins)) else $error("cause");
	a_read_fast: assert property (
		tk && !hwrite |=> hreadyout) else $error("wait");
	a_resp_okay: assert property (
		hresp == 1'b0) else $error("resp");
	a_rdata_quiet: assert property (
		!rp_q |-> hrdata == 32'h0) else $error("rdata");
	a_cond_width: assert property (
		rp_q && pa_q == OFF_COND |-> hrdata[31:4] == 28'h0) else $error("cond");
	a_xer_width: assert property (
		rp_q && pa_q == OFF_XER |-> hrdata[31:3] == 29'h0) else $error("xer");
	a_stat_clear: assert property (
		rp_q && pa_q == OFF_INT_STAT |=> !irq) else $error("irq");
	c_exec: cover property (ins);
	c_cond: cover property (rp_q && pa_q == OFF_COND);
	c_irq: cover property (irq);
endmodule : fpla_asserts
bind fpla_core fpla_asserts chk_u (.hclk, .hresetn, .hsel, .haddr, .htrans,
	.hwrite, .hsize, .hwdata, .hready, .hreadyout, .hresp, .hrdata, .irq);
`default_nettype wire

//--- testbench/fpla_master.sv
// bus master standing in for the instruction issuer
`timescale 1ns/10ps
`default_nettype none
module fpla_master
	import fpla_pkg::*;
(
	// clock
	input wire logic hclk,
	// request
	output logic hsel,
	output logic [ADDR_W-1:0] haddr,
	output logic [1:0] htrans,
	output logic hwrite,
	output logic [2:0] hsize,
	output logic [31:0] hwdata,
	// answer
	input wire logic hready,
	input wire logic [31:0] hrdata
);
	logic rdy_s;
	logic [31:0] rd_s;
	initial begin
		hsel = 1'b0;
		haddr = '0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = SIZE_WORD;
		hwdata = 32'h0;
	end
	// sampled mid-cycle so the edge never races the slave
	always @(negedge hclk) begin
		rdy_s = hready;
		rd_s = hrdata;
	end
	// entered just after a rising edge
	task automatic xfer(input logic w, input logic [ADDR_W-1:0] a,
		input logic [31:0] d, output logic [31:0] q);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= a;
		hwrite <= w;
		do @(posedge hclk); while (!rdy_s);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (!rdy_s);
		q = rd_s;
	endtask : xfer
endmodule : fpla_master
`default_nettype wire

//--- testbench/fixed_point_logical_alu_test.sv
// self-checking bench of the logical alu datapath
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin \
	total_checks++; \
	if ((g) !== (e)) begin \
		mismatches++; \
		$display("BAD t=%0t got=%h exp=%h", $time, g, e); \
	end \
end
module fixed_point_logical_alu_test
	import fpla_pkg::*;
;
	logic hclk = 1'b0;
	logic hresetn = 1'b0;
	logic hsel, hwrite, hreadyout, hresp, irq;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic [ADDR_W-1:0] haddr;
	logic [31:0] hwdata, hrdata, q, g_v, e_v, a, b;
	logic [31:0] gq[$], exp_q[$];
	int mismatches = 0;
	int total_checks = 0;
	always #50 hclk = ~hclk;
	fpla_master m_u (.hclk, .hsel, .haddr, .htrans, .hwrite, .hsize,
		.hwdata, .hready(hreadyout), .hrdata);
	fpla_core dut_u (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
		.hsize, .hwdata, .hready(hreadyout), .hreadyout, .hresp,
		.hrdata, .irq);
	always @(negedge hclk) begin
		while (gq.size() > 0) begin
			g_v = gq.pop_front();
			e_v = exp_q.pop_front();
			`CHK(g_v, e_v)
		end
	end
	task automatic wr(input logic [ADDR_W-1:0] ad, input logic [31:0] d);
		m_u.xfer(1'b1, ad, d, q);
	endtask : wr
	task automatic rd(input logic [ADDR_W-1:0] ad, input logic [31:0] e);
		exp_q.push_back(e);
		m_u.xfer(1'b0, ad, 32'h0, q);
		gq.push_back(q);
	endtask : rd
	task automatic gw(input logic [4:0] i, input logic [31:0] d);
		wr(OFF_REG_IDX, {27'h0, i});
		wr(OFF_REG_DATA, d);
	endtask : gw
	task automatic gr(input logic [4:0] i, input logic [31:0] e);
		wr(OFF_REG_IDX, {27'h0, i});
		rd(OFF_REG_DATA, e);
	endtask : gr
	task automatic ic(input logic e);
		@(negedge hclk);
		exp_q.push_back({31'h0, e});
		gq.push_back({31'h0, irq});
		@(posedge hclk);
	endtask : ic
	function automatic logic [31:0] lg(input logic [9:0] x, input logic r);
		return {PRIM_FIXED, 5'h4, 5'h6, 5'h7, x, r};
	endfunction : lg
	function automatic logic [31:0] ng(input logic oe, input logic r);
		return {PRIM_FIXED, 5'h6, 5'h4, 5'h0, oe, XO_NEG, r};
	endfunction : ng
	task automatic wrap_up;
		$display("checks %0d bad %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : wrap_up
	initial begin
		repeat (20000) @(posedge hclk);
		mismatches++;
		wrap_up();
	end
	initial begin
		void'($urandom(7));
		repeat (20) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		rd(OFF_XER, 32'h0);
		rd(8'h1c, 32'h0);
		for (int k = 0; k < 8; k++) begin
			a = $urandom();
			b = $urandom();
			gw(5'h4, a);
			gw(5'h7, b);
			wr(OFF_INSTR, lg(XO_NOR, 1'b0));
			gr(5'h6, ~(a | b));
			wr(OFF_INSTR, lg(XO_OR, 1'b0));
			gr(5'h6, a | b);
			wr(OFF_INSTR, lg(XO_ORC, 1'b0));
			gr(5'h6, a | ~b);
		end
		rd(OFF_COND, 32'h0);
		$display("test logical done");
		gw(5'h4, 32'hb004_3000);
		gw(5'h7, 32'h789a_789b);
		wr(OFF_INSTR, lg(XO_NOR, 1'b1));
		gr(5'h6, 32'h0761_8764);
		rd(OFF_COND, 32'h4);
		gw(5'h7, 32'hb004_3000);
		wr(OFF_INSTR, lg(XO_ORC, 1'b1));
		rd(OFF_COND, 32'h8);
		gw(5'h4, 32'h0);
		gw(5'h7, 32'h0);
		wr(OFF_INSTR, lg(XO_OR, 1'b1));
		rd(OFF_COND, 32'h2);
		rd(OFF_XER, 32'h0);
		$display("test record done");
		wr(OFF_XER, 32'h1);
		gw(5'h4, 32'h9000_3000);
		wr(OFF_INSTR, ng(1'b0, 1'b0));
		gr(5'h6, 32'h6fff_d000);
		rd(OFF_COND, 32'h2);
		gw(5'h4, 32'h789a_789b);
		wr(OFF_INSTR, ng(1'b0, 1'b1));
		gr(5'h6, 32'h8765_8765);
		rd(OFF_COND, 32'h8);
		gw(5'h4, MOST_NEG);
		wr(OFF_INSTR, ng(1'b1, 1'b1));
		gr(5'h6, MOST_NEG);
		rd(OFF_XER, 32'h7);
		rd(OFF_COND, 32'h9);
		gw(5'h4, 32'h1);
		wr(OFF_INSTR, ng(1'b1, 1'b0));
		rd(OFF_XER, 32'h5);
		wr(OFF_INSTR, lg(XO_OR, 1'b1));
		rd(OFF_COND, 32'h5);
		rd(OFF_XER, 32'h5);
		$display("test negate done");
		rd(OFF_INT_STAT, 32'h3);
		wr(OFF_INT_MASK, 32'h2);
		gw(5'h4, MOST_NEG);
		wr(OFF_INSTR, ng(1'b1, 1'b0));
		ic(1'b1);
		rd(OFF_INT_STAT, 32'h3);
		ic(1'b0);
		wr(OFF_INSTR, 32'h0);
		ic(1'b0);
		rd(OFF_INT_STAT, 32'h5);
		gr(5'h6, MOST_NEG);
		$display("test interrupt done");
		repeat (3) @(posedge hclk);
		wrap_up();
	end
endmodule : fixed_point_logical_alu_test
`default_nettype wire
